// *** bench/oba_chk.sv ***
// port assertions for the operand bus cycle sequencer
// assumes one clock domain and binding onto every oba_cycle instance
`timescale 1ns/1ps
`default_nettype none

module oba_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic phase_one,
	input wire logic phase_two,
	input wire logic phase_three,
	input wire logic phase_four,
	input wire logic exec_phase_n,
	input wire logic bus_request_n,
	input wire logic grant_ack_n,
	input wire logic grant_ack_oe,
	input wire logic op_addr_oe,
	input wire logic addr_strobe_n,
	input wire logic data_strobe_n,
	input wire logic bus_ctl_oe,
	input wire logic cycle_done,
	input wire logic cycle_err
);
	// ----------------------------------------
	// phase sequence and bus ownership
	// ----------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	phase_hot_a: assert property (
		$onehot({phase_one, phase_two, phase_three, phase_four})) else $error("phase not one-hot");
	one_len_a: assert property (
		$rose(phase_one) |-> phase_one [*8] ##1 phase_two) else $error("phase one length");
	exec_low_a: assert property (
		phase_one || phase_two |-> !exec_phase_n) else $error("indicator high early");
	exec_high_a: assert property (
		phase_three || phase_four |-> exec_phase_n) else $error("indicator low late");
	ds_late_a: assert property (
		$fell(data_strobe_n) |-> phase_four && $past(phase_four, 8) && !$past(phase_four, 9))
		else $error("data strobe timing");
	strobe_rel_a: assert property (
		$rose(phase_one) && !addr_strobe_n |-> !addr_strobe_n [*8] ##1
		(addr_strobe_n && data_strobe_n)) else $error("strobe release");
	bus_float_a: assert property (
		$rose(phase_one) && op_addr_oe |-> op_addr_oe [*8]) else $error("bus floated early");
	own_norq_a: assert property (
		!grant_ack_n && grant_ack_oe |-> bus_request_n) else $error("request while owner");
	req_ph2_a: assert property (
		!bus_request_n |-> phase_two) else $error("request outside phase two");
	drive_own_a: assert property (
		op_addr_oe |-> grant_ack_oe && !grant_ack_n) else $error("bus driven unowned");
	strobe_oe_a: assert property (
		!addr_strobe_n || !data_strobe_n |-> bus_ctl_oe) else $error("strobe undriven");
	err_done_a: assert property (
		cycle_err |-> cycle_done) else $error("error without done");
	done_p1_a: assert property (
		cycle_done |-> $rose(phase_one)) else $error("done off phase one");
	as_ph3_a: assert property (
		$rose(phase_three) && op_addr_oe |-> !addr_strobe_n && bus_ctl_oe && !grant_ack_n)
		else $error("phase three launch");

	cover property (cycle_err);
	cover property (phase_two [*8] ##1 phase_two);
	cover property (phase_four [*8] ##1 phase_four);
endmodule

bind oba_cycle oba_chk chk (.clk_sys, .rst_n, .phase_one, .phase_two, .phase_three, .phase_four,
	.exec_phase_n, .bus_request_n, .grant_ack_n, .grant_ack_oe, .op_addr_oe, .addr_strobe_n,
	.data_strobe_n, .bus_ctl_oe, .cycle_done, .cycle_err);
`default_nettype wire

// *** bench/oba_far.sv ***
// far side of the operand bus: arbiter, another master and a slave
// assumes pull-ups on acknowledge, fault and protect; knobs held per cycle
`timescale 1ns/1ps
`default_nettype none

module oba_far (
	input  wire logic        clk_sys,
	input  wire logic        bus_request_n,
	input  wire logic        data_strobe_n,
	input  wire logic        rd_wr_n,
	input  wire logic [4:0]  wdly,
	input  wire logic [1:0]  err_sel,
	input  wire logic        busy_on,
	input  wire logic [15:0] rdata,
	output logic             grant_in_n,
	output logic             bus_busy_n,
	output logic             xfer_ack_n,
	output logic             bus_fault_n,
	output logic             mem_protect_n,
	output logic [15:0]      op_data_i
);
	logic [5:0] rq_cnt = 6'h00;
	logic [5:0] ds_cnt = 6'h00;
	logic [4:0] w_r = 5'h00;
	logic [1:0] e_r = 2'h0;

	// ----------------------------------------
	// arbitration and slave answer
	// ----------------------------------------
	initial {grant_in_n, bus_busy_n, xfer_ack_n, bus_fault_n, mem_protect_n} = 5'h1f;
	initial op_data_i = 16'h0000;

	// delay and error knobs latch while strobe is idle so a mid-cycle change cannot bite
	always @(posedge clk_sys) begin
		rq_cnt <= bus_request_n ? 6'h00 : rq_cnt + 6'(rq_cnt != 6'h3f);
		grant_in_n <= bus_request_n;
		bus_busy_n <= bus_request_n || !busy_on || rq_cnt >= 6'd30;
		if (data_strobe_n) begin
			ds_cnt <= 6'h00;
			w_r <= wdly;
			e_r <= err_sel;
		end else
			ds_cnt <= ds_cnt + 6'(ds_cnt != 6'h3f);
		xfer_ack_n <= !(!data_strobe_n && ds_cnt >= 6'(w_r) && e_r == 2'h0);
		bus_fault_n <= !(!data_strobe_n && ds_cnt >= 6'(w_r) && e_r == 2'h1);
		mem_protect_n <= !(!data_strobe_n && ds_cnt >= 6'(w_r) && e_r == 2'h2);
		// released data toggles so a stale value cannot pass
		op_data_i <= (!data_strobe_n && rd_wr_n) ? rdata : ~op_data_i;
	end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// random and corner instruction streams through the bus sequencer
// assumes oba_far answers the operand bus; 200 MHz clock
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	typedef struct {logic nd, wr, io, oi, bz; logic [1:0] x, w, er;
		logic [19:0] fa; logic [15:0] ad, wd, ir, rd;} oba_ins_t;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [19:0] next_fetch_addr;
	logic [15:0] imem_rdata, op_addr, op_wdata, rdata, op_data_i;
	logic op_need, op_write, op_io, op_instr, imem_store_op, imem_load_op, long_imm, busy_on;
	logic [4:0] wdly;
	logic [1:0] err_sel;
	logic grant_in_n, bus_busy_n, xfer_ack_n, bus_fault_n, mem_protect_n;
	wire logic instr_take, cycle_done, cycle_err, exec_phase_n, bus_request_n, grant_ack_n;
	wire logic phase_one, phase_two, phase_three, phase_four, grant_ack_oe, op_addr_oe;
	wire logic op_data_oe, addr_strobe_n, data_strobe_n, rd_wr_n, mem_io_sel;
	wire logic operand_instr_sel, bus_ctl_oe;
	wire logic [15:0] rd_data_r, primary_instr_latch, op_addr_o, op_data_o;
	wire logic [19:0] imem_addr_r;
	int n_fail = 0;
	int checks_done = 0;

	always #2.5 clk_sys = ~clk_sys;

	oba_cycle dut (.clk_sys, .rst_n, .next_fetch_addr, .imem_rdata, .op_need, .op_write,
		.op_io, .op_instr, .imem_store_op, .imem_load_op, .long_imm, .op_addr, .op_wdata,
		.instr_take, .cycle_done, .cycle_err, .rd_data_r, .imem_addr_r, .primary_instr_latch,
		.exec_phase_n, .phase_one, .phase_two, .phase_three, .phase_four, .bus_request_n,
		.grant_in_n, .bus_busy_n, .grant_ack_n, .grant_ack_oe, .op_addr_o, .op_addr_oe,
		.op_data_o, .op_data_oe, .op_data_i, .addr_strobe_n, .data_strobe_n, .rd_wr_n,
		.mem_io_sel, .operand_instr_sel, .bus_ctl_oe, .xfer_ack_n, .bus_fault_n, .mem_protect_n);
	oba_far far (.clk_sys, .bus_request_n, .data_strobe_n, .rd_wr_n, .wdly, .err_sel, .busy_on,
		.rdata, .grant_in_n, .bus_busy_n, .xfer_ack_n, .bus_fault_n, .mem_protect_n, .op_data_i);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask

	// first instructions are fixed corners, the rest random
	function automatic oba_ins_t gen(input int i);
		oba_ins_t t;
		{t.nd, t.wr, t.io, t.oi, t.bz, t.x, t.w, t.fa} = 29'($urandom);
		{t.ad, t.wd} = $urandom;
		{t.ir, t.rd} = $urandom;
		t.er = 2'($urandom % 6);
		if (t.er > 2'h2 || i > 6 && t.w == 2'h3) {t.er, t.w} = 4'h0;
		case (i)
			0: {t.nd, t.x} = 3'h0;
			1: {t.nd, t.wr, t.bz, t.w, t.er} = 7'h50;
			2: {t.nd, t.wr, t.bz, t.w, t.er} = 7'h78;
			3: {t.nd, t.er} = 3'h5;
			4: {t.nd, t.er, t.x} = 5'h1b;
			5: t.nd = 1'b0;
			6: {t.nd, t.bz, t.x} = 4'hd;
			default: ;
		endcase
		if (t.w == 2'h3) t.w = 2'h2;
		return t;
	endfunction

	// clocks from one phase-one entry to the next
	function automatic int exp_len(input oba_ins_t t, input logic own);
		int p2;
		p2 = (t.nd && !own && t.bz) ? 40 : (t.x != 2'h0 ? 24 : 8);
		return 16 + p2 + (t.nd ? 24 + 16 * t.w : 8);
	endfunction

	task automatic apply(input oba_ins_t t);
		{op_need, op_write, op_io, op_instr} = {t.nd, t.wr, t.io, t.oi};
		{imem_store_op, imem_load_op, long_imm} = {t.x == 2'h1, t.x == 2'h2, t.x == 2'h3};
		{next_fetch_addr, op_addr, op_wdata, imem_rdata} = {t.fa, t.ad, t.wd, t.ir};
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		oba_ins_t cur, nx;
		int n;
		logic own, seen_as, seen_p3, done;
		{wdly, err_sel, busy_on, rdata} = 24'h0;
		void'($urandom(32'h0e0c));
		nx = gen(0);
		apply(nx);
		own = 1'b0;
		repeat (20) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		n = 0;
		while (!instr_take && n < 40) begin
			tick;
			n++;
		end
		if (!instr_take) begin
			n_fail++;
			close_out;
		end
		for (int i = 1; i <= 48; i++) begin
			cur = nx;
			repeat (2) tick;
			check(imem_addr_r, cur.fa);
			wdly = cur.w == 2'h0 ? 5'h00 : 5'(cur.w * 16 - 4);
			{err_sel, busy_on, rdata} = {cur.er, cur.bz, cur.rd};
			repeat (8) tick;
			nx = gen(i);
			apply(nx);
			{n, seen_as, seen_p3, done} = {32'd10, 3'b000};
			while (!instr_take && n < 400) begin
				tick;
				n++;
				if (phase_three && !seen_p3) begin
					seen_p3 = 1'b1;
					check({op_addr_oe, bus_ctl_oe, grant_ack_oe}, {3{cur.nd}});
					check(op_data_oe, cur.nd && cur.wr);
				end
				if (!addr_strobe_n && !seen_as) begin
					seen_as = 1'b1;
					check(op_addr_o, cur.ad);
					check({rd_wr_n, mem_io_sel}, {!cur.wr, cur.io});
					check({operand_instr_sel, grant_ack_n}, {cur.oi, 1'b0});
					if (cur.wr) check(op_data_o, cur.wd);
				end
				if (cycle_done) begin
					done = 1'b1;
					check(cycle_err, cur.er != 2'h0);
					if (!cur.wr && cur.er == 2'h0) check(rd_data_r, cur.rd);
				end
			end
			if (!instr_take) begin
				n_fail++;
				close_out;
			end
			check(n, exp_len(cur, own));
			check(primary_instr_latch, nx.ir);
			check(done, cur.nd);
			own = cur.nd;
		end
		close_out;
	end
endmodule
`default_nettype wire

// *** rtl/oba_cycle.v ***
// four-phase operand bus cycle sequencer with master-side arbitration
// assumes one system clock; the processor clock is a divided enable,
// instruction fields are stable from phase two of the previous cycle through phase one
`timescale 1ns/1ps
`default_nettype none
`include "oba_regs.vh"

// Behaviour
// R1: each cycle runs phases one to four
// R2: phase one executes, drives fetch address, indicator low
// R3: stretch phase two for imem ops, long immediates
// R4: falling edge samples busy AND not-grant; extend low
// R5: indicator low in two, high from three
// R6: phase three drives buses, ack, strobe, qualifiers
// R7: phase four opens primary instruction latch
// R8: data strobe low half clock into four
// R9: sample acknowledge each rise, stretch phase four
// R10: fault or protect ends cycle as error
// R11: non-operand instructions take two clocks
// R12: four cycle kinds differ only by qualifiers
// R13: strobes release at first rise after four
// R14: bus floats one clock after four ends
// R15: request at phase two, sample each fall
// R16: ownership keeps ack, no further requests
// R17: ack released at three of non-bus cycle
// R18: arbiter grants low for highest priority
// R19: other masters hold busy while using bus
// R20: slave acknowledge late inserts wait states
// R21: arbitration signals are all active low
// R22: bus outputs driven only while master
// R23: asynchronous inputs pass two flip-flops
module oba_cycle (
	input  wire                clk_sys,
	input  wire                rst_n,
	// instruction side
	input  wire [`OBA_IAW-1:0] next_fetch_addr,
	input  wire [`OBA_DW-1:0]  imem_rdata,
	input  wire                op_need,
	input  wire                op_write,
	input  wire                op_io,
	input  wire                op_instr,
	input  wire                imem_store_op,
	input  wire                imem_load_op,
	input  wire                long_imm,
	input  wire [`OBA_AW-1:0]  op_addr,
	input  wire [`OBA_DW-1:0]  op_wdata,
	output reg                 instr_take,
	output reg                 cycle_done,
	output reg                 cycle_err,
	output reg  [`OBA_DW-1:0]  rd_data_r,
	output reg  [`OBA_IAW-1:0] imem_addr_r,
	output reg  [`OBA_DW-1:0]  primary_instr_latch,
	output reg                 exec_phase_n,
	output wire                phase_one,
	output wire                phase_two,
	output wire                phase_three,
	output wire                phase_four,
	// arbitration pins
	output reg                 bus_request_n,
	input  wire                grant_in_n,
	input  wire                bus_busy_n,
	output reg                 grant_ack_n,
	output reg                 grant_ack_oe,
	// operand bus pins
	output reg  [`OBA_AW-1:0]  op_addr_o,
	output reg                 op_addr_oe,
	output reg  [`OBA_DW-1:0]  op_data_o,
	output reg                 op_data_oe,
	input  wire [`OBA_DW-1:0]  op_data_i,
	output reg                 addr_strobe_n,
	output reg                 data_strobe_n,
	output reg                 rd_wr_n,
	output reg                 mem_io_sel,
	output reg                 operand_instr_sel,
	output reg                 bus_ctl_oe,
	input  wire                xfer_ack_n,
	input  wire                bus_fault_n,
	input  wire                mem_protect_n
);

	// ----------------------------------------------------------------
	// phase codes
	// ----------------------------------------------------------------
	localparam [3:0] PH1 = `OBA_PH_ONE;
	localparam [3:0] PH2 = `OBA_PH_TWO;
	localparam [3:0] PH3 = `OBA_PH_THREE;
	localparam [3:0] PH4 = `OBA_PH_FOUR;
	// terminal count of the half-period divider, cut to the counter width
	localparam [31:0]           HALF_CNT  = `OBA_HALF_CYC - 1;
	localparam [`OBA_CNT_W-1:0] HALF_LAST = HALF_CNT[`OBA_CNT_W-1:0];

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	wire [`OBA_SYNC_W-1:0] sync_q;
	wire                   grant_s;
	wire                   busy_s;
	wire                   ack_s;
	wire                   fault_s;
	wire                   prot_s;
	wire [`OBA_DW-1:0]     data_s;

	// pins idle high, so the stages reset high except data
	oba_sync #(
		.W    (`OBA_SYNC_W),
		.INIT ({5'h1f, 16'h0000})
	) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d_in    ({grant_in_n, bus_busy_n, xfer_ack_n, bus_fault_n,
		           mem_protect_n, op_data_i}),
		.q_out   (sync_q)
	); // R23
	// slices follow the order of the concatenation above
	assign grant_s = sync_q[20];
	assign busy_s  = sync_q[19];
	assign ack_s   = sync_q[18];
	assign fault_s = sync_q[17];
	assign prot_s  = sync_q[16];
	assign data_s  = sync_q[15:0];

	// ----------------------------------------------------------------
	// processor clock divider
	// ----------------------------------------------------------------
	reg [`OBA_CNT_W-1:0] cnt_r;
	reg                  pclk_hi_r;
	wire                 tick;
	wire                 p_rise;
	wire                 p_fall;

	assign tick   = (cnt_r == HALF_LAST);
	assign p_rise = tick & ~pclk_hi_r;
	assign p_fall = tick & pclk_hi_r;

	// starts high so the first event is a falling edge into phase one
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r     <= {`OBA_CNT_W{1'b0}};
			pclk_hi_r <= 1'b1;
		end else if (tick) begin
			cnt_r     <= {`OBA_CNT_W{1'b0}};
			pclk_hi_r <= ~pclk_hi_r;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// sequencer state
	// ----------------------------------------------------------------
	reg [3:0] phase_r;
	reg       need_r;
	reg       write_r;
	reg       ext_r;
	reg       owned_r;
	reg       ds_on_r;
	reg       done_r;
	reg       err_r;
	reg       rel_pend_r;
	reg       flt_pend_r;

	// operand fields wait here until phase three, so the bus never moves under a live strobe
	reg [`OBA_AW-1:0] addr_hold_r;
	reg [`OBA_DW-1:0] wdata_hold_r;
	reg               io_hold_r;
	reg               oi_hold_r;
	wire      arb_ok;

	// high means the bus is free and ours to take
	assign arb_ok = busy_s & ~grant_s; // R4 R21

	assign phase_one   = phase_r[0];
	assign phase_two   = phase_r[1];
	assign phase_three = phase_r[2];
	assign phase_four  = phase_r[3];

	// ----------------------------------------------------------------
	// phase machine and bus drive
	// ----------------------------------------------------------------
	// a stretched phase only waits for the next edge of its own kind,
	// so every stretch costs a whole processor clock
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_r       <= PH4;
			need_r        <= 1'b0;
			write_r       <= 1'b0;
			ext_r         <= 1'b0;
			owned_r       <= 1'b0;
			ds_on_r       <= 1'b0;
			done_r        <= 1'b0;
			err_r         <= 1'b0;
			rel_pend_r    <= 1'b0;
			flt_pend_r    <= 1'b0;
			addr_hold_r   <= 16'h0000;
			wdata_hold_r  <= 16'h0000;
			io_hold_r     <= 1'b0;
			oi_hold_r     <= 1'b0;
			instr_take    <= 1'b0;
			cycle_done    <= 1'b0;
			cycle_err     <= 1'b0;
			rd_data_r     <= 16'h0000;
			imem_addr_r   <= 20'h00000;
			exec_phase_n  <= 1'b1;
			bus_request_n <= 1'b1;
			grant_ack_n   <= 1'b1;
			grant_ack_oe  <= 1'b0;
			op_addr_o     <= 16'h0000;
			op_addr_oe    <= 1'b0;
			op_data_o     <= 16'h0000;
			op_data_oe    <= 1'b0;
			addr_strobe_n <= 1'b1;
			data_strobe_n <= 1'b1;
			rd_wr_n       <= 1'b1;
			mem_io_sel    <= 1'b0;
			operand_instr_sel <= 1'b0;
			bus_ctl_oe    <= 1'b0;
		end else begin
			instr_take <= 1'b0;
			cycle_done <= 1'b0;
			cycle_err  <= 1'b0;
			case (phase_r)
			PH1: begin
				// strobes rise on the first rising edge after four
				if (p_rise) begin
					if (rel_pend_r) begin
						addr_strobe_n <= 1'b1; // R13
						data_strobe_n <= 1'b1; // R13
						rel_pend_r    <= 1'b0;
					end
					ext_r   <= imem_store_op | imem_load_op | long_imm; // R3
					phase_r <= PH2; // R1
					if (need_r && !owned_r) begin
						bus_request_n <= 1'b0; // R15 R21
					end
				end
			end
			PH2: begin
				if (p_fall) begin
					// bus lines float one clock after four ended
					if (flt_pend_r) begin
						op_addr_oe <= 1'b0; // R14 R22
						op_data_oe <= 1'b0; // R14 R22
						bus_ctl_oe <= 1'b0; // R14 R22
						flt_pend_r <= 1'b0;
					end
					if (ext_r) begin
						ext_r <= 1'b0; // R3
					end else if (need_r && !owned_r && !arb_ok) begin
						phase_r <= PH2; // R4 R15
					end else begin
						phase_r      <= PH3; // R1
						exec_phase_n <= 1'b1; // R5
						if (need_r) begin
							// one drive path for all four cycle kinds
							owned_r       <= 1'b1; // R16
							bus_request_n <= 1'b1; // R16
							grant_ack_n   <= 1'b0; // R6 R16
							grant_ack_oe  <= 1'b1; // R6
							addr_strobe_n <= 1'b0; // R6
							op_addr_oe    <= 1'b1; // R6 R22
							op_data_oe    <= write_r; // R6 R12
							bus_ctl_oe    <= 1'b1; // R6 R22
							op_addr_o         <= addr_hold_r; // R6 R12
							op_data_o         <= wdata_hold_r; // R12
							rd_wr_n           <= ~write_r; // R6 R12
							mem_io_sel        <= io_hold_r; // R6 R12
							operand_instr_sel <= oi_hold_r; // R6
						end else if (owned_r) begin
							owned_r      <= 1'b0; // R17
							grant_ack_n  <= 1'b1; // R17
							grant_ack_oe <= 1'b0; // R17 R22
						end
					end
				end
			end
			PH3: begin
				if (p_rise) begin
					// clear the per-cycle handshake flags before data strobe goes out
					phase_r <= PH4; // R1
					ds_on_r <= 1'b0;
					done_r  <= 1'b0;
					err_r   <= 1'b0;
				end
			end
			PH4: begin
				if (p_fall) begin
					if (need_r && !ds_on_r) begin
						data_strobe_n <= 1'b0; // R8
						ds_on_r       <= 1'b1; // R8
					end else if (!need_r || done_r) begin
						// close the cycle and start the next one
						phase_r      <= PH1; // R1 R11
						exec_phase_n <= 1'b0; // R2
						imem_addr_r  <= next_fetch_addr; // R2
						instr_take   <= 1'b1;
						need_r       <= op_need;
						write_r      <= op_write;
						if (op_need) begin
							// held back: the previous cycle's strobes may still be low
							addr_hold_r  <= op_addr;
							wdata_hold_r <= op_wdata;
							io_hold_r    <= op_io;
							oi_hold_r    <= op_instr;
						end
						if (need_r) begin
							cycle_done <= 1'b1;
							cycle_err  <= err_r; // R10
							rel_pend_r <= 1'b1; // R13
							flt_pend_r <= 1'b1; // R14
						end
					end
				end else if (p_rise && ds_on_r && !done_r) begin
					// late acknowledge simply means more wait states
					if (!ack_s || !fault_s || !prot_s) begin
						done_r <= 1'b1; // R9 R20
						err_r  <= ~fault_s | ~prot_s; // R10
						if (!write_r) begin
							rd_data_r <= data_s;
						end
					end
				end
			end
			default: begin
				phase_r <= PH4;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// primary instruction latch
	// ----------------------------------------------------------------
	// transparent for all of phase four, holds from the next phase one
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			primary_instr_latch <= 16'h0000;
		end else if (phase_r == PH4) begin
			primary_instr_latch <= imem_rdata; // R7
		end
	end

endmodule

`default_nettype wire

// *** rtl/oba_regs.vh ***
// timing and encoding constants for the operand bus cycle sequencer
// assumes a 200 MHz system clock; no software registers exist
`ifndef OBA_REGS_VH
`define OBA_REGS_VH

// ----------------------------------------------------------------
// clock rates
// ----------------------------------------------------------------
`define OBA_SYS_PERIOD_PS   5000
`define OBA_PROC_HALF_PS    40000
`define OBA_HALF_CYC        (`OBA_PROC_HALF_PS / `OBA_SYS_PERIOD_PS)
`define OBA_CNT_W           4

// ----------------------------------------------------------------
// one-hot phase codes
// ----------------------------------------------------------------
`define OBA_PH_ONE          4'h1
`define OBA_PH_TWO          4'h2
`define OBA_PH_THREE        4'h4
`define OBA_PH_FOUR         4'h8

// ----------------------------------------------------------------
// bus widths
// ----------------------------------------------------------------
`define OBA_AW              16
`define OBA_DW              16
`define OBA_IAW             20
`define OBA_SYNC_W          21

`endif

// *** rtl/oba_sync.v ***
// two-flop synchroniser, one stage pair per bit
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none

module oba_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input  wire         clk_sys,
	input  wire         rst_n,
	input  wire [W-1:0] d_in,
	output wire [W-1:0] q_out
);

	// ----------------------------------------------------------------
	// per-bit stages
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg s1_r;
			reg s2_r;
			// first stage feeds only the second
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					s1_r <= INIT[i];
					s2_r <= INIT[i];
				end else begin
					s1_r <= d_in[i];
					s2_r <= s1_r;
				end
			end
			assign q_out[i] = s2_r;
		end
	endgenerate

endmodule

`default_nettype wire
